// ---- lchm_top.sv ----
// health word, monitor pointer wrap and axi4-lite registers
// How it works
// RULE_01 - each capture with monitor enabled stores its descriptor at pointer, then pointer steps eight, except after the extra message.
// RULE_02 - reaching block count raises block count interrupt, pointer not reloaded.
// RULE_03 - one more message then lands at the next sequential address.
// RULE_04 - after that extra message the pointer reloads to its initial value.
// RULE_05 - block count interrupt loads interrupt address word with last descriptor.
// RULE_06 - health bit 15 sets on a failed backend memory access.
// RULE_07 - health bit 14 sets on transmitter loopback failure.
// RULE_08 - health bit 13 sets on terminal address parity error.
// RULE_09 - health bit 11 sets on channel A transmitter timeout.
// RULE_10 - health bit 10 sets on channel B transmitter timeout.
// RULE_11 - hardware never sets health bit 12 or bits 9 to 0.
// RULE_12 - host may write every health bit, set or clear.
// RULE_13 - after reset health bits 9 to 0 hold the version code.
// RULE_14 - buffered data mode bit 6 is not implemented, reads zero.
// RULE_15 - host must program all configuration before operation.
// RULE_16 - legacy write strobe low only when select and read/write low.
// RULE_17 - legacy data input muxes backend read data or host write data.
// RULE_18 - legacy interrupt pins are inverted core interrupt outputs.
// RULE_19 - terminal active is inverted busy; rom enable held high.
`timescale 1ns/1ps
module lchm_top #(
   parameter logic [9:0] VERSION = 10'h2a5 // arbitrary value
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic [2:0] i_s_axi_awprot,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   output logic [1:0] o_s_axi_bresp,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [7:0] i_s_axi_araddr,
   input wire logic [2:0] i_s_axi_arprot,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic i_msg_captured,
   input wire lchm_pkg::lchm_health_evt_t i_health_evt,
   input wire logic [4:0] i_terminal_address_in,
   input wire logic i_terminal_addr_parity_in,
   input wire logic i_core_busy,
   input wire logic i_legacy_chip_select_n,
   input wire logic i_legacy_read_write_n,
   input wire logic [15:0] i_backend_read_data,
   input wire logic [15:0] i_host_write_data,
   input wire logic i_data_sel_backend,
   input wire logic i_backend_data_drive_en,
   input wire logic i_host_data_drive_en,
   output lchm_pkg::lchm_desc_wr_t o_desc_wr,
   output logic o_terminal_addr_error,
   output logic o_irq,
   output logic o_host_write_strobe_n,
   output logic o_host_write_n,
   output logic o_legacy_high_irq_n,
   output logic o_legacy_message_irq_n,
   output logic o_legacy_terminal_active_n,
   output logic o_legacy_rom_enable_n,
   output logic [15:0] o_legacy_data_input,
   output logic o_legacy_data_drive_en
);
   logic aw_have_r, w_have_r;
   logic [7:0] wr_addr_r;
   logic [31:0] wr_data_r;
   logic [3:0] wr_strb_r;
   logic wr_do;
   logic wr_hit;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic ctrl_mon_en_r;
   logic [15:0] init_ptr_r, blk_cnt_r, ptr_r, count_r, iaw_r;
   logic extra_r;
   logic blk_evt;
   logic [15:0] health_r, health_nxt;
   logic [4:0] taddr_s1_r, taddr_s2_r;
   logic par_s1_r, par_s2_r;
   logic tapar_err;
   logic [lchm_pkg::IRQ_W-1:0] int_stat_r, int_stat_nxt, int_mask_r;
   logic health_evt_any;
   logic wr_health;

   // axi write channels, taken in either order
   assign wr_do = aw_have_r && w_have_r && !o_s_axi_bvalid;
   always_comb begin
      case (wr_addr_r)
         lchm_pkg::ADDR_CTRL, lchm_pkg::ADDR_INIT_PTR,
         lchm_pkg::ADDR_BLK_CNT, lchm_pkg::ADDR_MON_PTR,
         lchm_pkg::ADDR_IAW, lchm_pkg::ADDR_HEALTH,
         lchm_pkg::ADDR_INT_STAT, lchm_pkg::ADDR_INT_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         wr_addr_r <= 8'h00;
         wr_data_r <= 32'h0000_0000;
         wr_strb_r <= 4'h0;
         o_s_axi_awready <= 1'b1;
         o_s_axi_wready <= 1'b1;
         o_s_axi_bvalid <= 1'b0;
         o_s_axi_bresp <= lchm_pkg::RESP_OKAY;
      end else begin
         if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_have_r <= 1'b1;
            wr_addr_r <= i_s_axi_awaddr;
            o_s_axi_awready <= 1'b0;
         end
         if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_have_r <= 1'b1;
            wr_data_r <= i_s_axi_wdata;
            wr_strb_r <= i_s_axi_wstrb;
            o_s_axi_wready <= 1'b0;
         end
         if (wr_do) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            o_s_axi_bvalid <= 1'b1;
            o_s_axi_bresp <= wr_hit ? lchm_pkg::RESP_OKAY
                                    : lchm_pkg::RESP_SLVERR;
         end
         if (o_s_axi_bvalid && i_s_axi_bready) begin
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_awready <= 1'b1;
            o_s_axi_wready <= 1'b1;
         end
      end
   end

   // read side
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (i_s_axi_araddr)
         lchm_pkg::ADDR_CTRL: rd_mux[lchm_pkg::CTRL_MON_EN] = ctrl_mon_en_r;
         lchm_pkg::ADDR_INIT_PTR: rd_mux[15:0] = init_ptr_r;
         lchm_pkg::ADDR_BLK_CNT: rd_mux[15:0] = blk_cnt_r;
         lchm_pkg::ADDR_MON_PTR: rd_mux[15:0] = ptr_r;
         lchm_pkg::ADDR_IAW: rd_mux[15:0] = iaw_r;
         lchm_pkg::ADDR_HEALTH: rd_mux[15:0] = health_r;
         lchm_pkg::ADDR_INT_STAT: rd_mux[lchm_pkg::IRQ_W-1:0] = int_stat_r;
         lchm_pkg::ADDR_INT_MASK: rd_mux[lchm_pkg::IRQ_W-1:0] = int_mask_r;
         default: rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_s_axi_arready <= 1'b1;
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_rdata <= 32'h0000_0000;
         o_s_axi_rresp <= lchm_pkg::RESP_OKAY;
      end else if (i_s_axi_arvalid && o_s_axi_arready) begin
         o_s_axi_arready <= 1'b0;
         o_s_axi_rvalid <= 1'b1;
         o_s_axi_rdata <= rd_mux;
         o_s_axi_rresp <= rd_hit ? lchm_pkg::RESP_OKAY
                                 : lchm_pkg::RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
         o_s_axi_rvalid <= 1'b0;
         o_s_axi_arready <= 1'b1;
      end
   end

   // configuration; buffered mode bit is not stored
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_mon_en_r <= 1'b0;
         init_ptr_r <= lchm_pkg::INIT_PTR_RST;
         blk_cnt_r <= lchm_pkg::BLK_CNT_RST;
         int_mask_r <= '0;
      end else if (wr_do) begin
         if (wr_addr_r == lchm_pkg::ADDR_CTRL && wr_strb_r[0])
            ctrl_mon_en_r <= wr_data_r[lchm_pkg::CTRL_MON_EN]; // RULE_14
         if (wr_addr_r == lchm_pkg::ADDR_INIT_PTR) begin
            if (wr_strb_r[0]) init_ptr_r[7:0] <= wr_data_r[7:0];
            if (wr_strb_r[1]) init_ptr_r[15:8] <= wr_data_r[15:8];
         end
         if (wr_addr_r == lchm_pkg::ADDR_BLK_CNT) begin
            if (wr_strb_r[0]) blk_cnt_r[7:0] <= wr_data_r[7:0];
            if (wr_strb_r[1]) blk_cnt_r[15:8] <= wr_data_r[15:8];
         end
         if (wr_addr_r == lchm_pkg::ADDR_INT_MASK && wr_strb_r[0])
            int_mask_r <= wr_data_r[lchm_pkg::IRQ_W-1:0];
      end
   end

   // monitor descriptor pointer and block count wrap
   assign blk_evt = ctrl_mon_en_r && i_msg_captured && !extra_r &&
                    (count_r + lchm_pkg::ONE16 == blk_cnt_r);
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ptr_r <= lchm_pkg::INIT_PTR_RST;
         count_r <= 16'h0000;
         extra_r <= 1'b0;
         iaw_r <= 16'h0000;
         o_desc_wr <= '0;
      end else begin
         o_desc_wr.valid <= ctrl_mon_en_r && i_msg_captured;
         if (!ctrl_mon_en_r) begin
            ptr_r <= init_ptr_r;
            count_r <= 16'h0000;
            extra_r <= 1'b0;
         end else if (i_msg_captured) begin
            o_desc_wr.addr <= ptr_r; // RULE_01
            if (extra_r) begin
               ptr_r <= init_ptr_r; // RULE_04
               count_r <= 16'h0000;
               extra_r <= 1'b0;
            end else begin
               ptr_r <= ptr_r + lchm_pkg::DESC_STRIDE; // RULE_01 RULE_03
               if (blk_evt) begin
                  extra_r <= 1'b1; // RULE_02
                  iaw_r <= ptr_r; // RULE_05
               end else begin
                  count_r <= count_r + lchm_pkg::ONE16;
               end
            end
         end
      end
   end

   // terminal address pin synchronisers, odd parity expected
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         taddr_s1_r <= 5'h00;
         taddr_s2_r <= 5'h00;
         par_s1_r <= 1'b1;
         par_s2_r <= 1'b1;
         o_terminal_addr_error <= 1'b0;
      end else begin
         taddr_s1_r <= i_terminal_address_in;
         taddr_s2_r <= taddr_s1_r;
         par_s1_r <= i_terminal_addr_parity_in;
         par_s2_r <= par_s1_r;
         o_terminal_addr_error <= tapar_err;
      end
   end
   assign tapar_err = !(^{taddr_s2_r, par_s2_r});

   // health word: hardware sets win over a host write
   assign wr_health = wr_do && wr_addr_r == lchm_pkg::ADDR_HEALTH;
   always_comb begin
      health_nxt = health_r;
      if (wr_health) begin // RULE_12
         if (wr_strb_r[0]) health_nxt[7:0] = wr_data_r[7:0];
         if (wr_strb_r[1]) health_nxt[15:8] = wr_data_r[15:8];
      end
      if (i_health_evt.mem_fail) health_nxt[lchm_pkg::HB_MEM] = 1'b1; // RULE_06
      if (i_health_evt.loop_fail) health_nxt[lchm_pkg::HB_LOOP] = 1'b1; // RULE_07
      if (tapar_err) health_nxt[lchm_pkg::HB_TAPAR] = 1'b1; // RULE_08
      if (i_health_evt.tx_timeout_a) health_nxt[lchm_pkg::HB_TXA] = 1'b1; // RULE_09
      if (i_health_evt.tx_timeout_b) health_nxt[lchm_pkg::HB_TXB] = 1'b1; // RULE_10
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) health_r <= {6'h00, VERSION}; // RULE_13
      else health_r <= health_nxt; // RULE_11
   end

   // interrupt status, write one to clear, set wins
   assign health_evt_any = i_health_evt.mem_fail | i_health_evt.loop_fail |
                           i_health_evt.tx_timeout_a |
                           i_health_evt.tx_timeout_b | tapar_err;
   always_comb begin
      int_stat_nxt = int_stat_r;
      if (wr_do && wr_addr_r == lchm_pkg::ADDR_INT_STAT && wr_strb_r[0])
         int_stat_nxt = int_stat_r & ~wr_data_r[lchm_pkg::IRQ_W-1:0];
      if (blk_evt) int_stat_nxt[lchm_pkg::IRQ_BLK] = 1'b1; // RULE_02
      if (health_evt_any) int_stat_nxt[lchm_pkg::IRQ_HEALTH] = 1'b1;
   end
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         int_stat_r <= '0;
         o_irq <= 1'b0;
      end else begin
         int_stat_r <= int_stat_nxt;
         o_irq <= |(int_stat_r & int_mask_r);
      end
   end

   lchm_legacy_wrap u_wrap (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_legacy_chip_select_n(i_legacy_chip_select_n),
      .i_legacy_read_write_n(i_legacy_read_write_n),
      .i_high_prio_irq_out(int_stat_r[lchm_pkg::IRQ_HEALTH] &
                           int_mask_r[lchm_pkg::IRQ_HEALTH]),
      .i_message_irq_out(int_stat_r[lchm_pkg::IRQ_BLK] &
                         int_mask_r[lchm_pkg::IRQ_BLK]),
      .i_core_busy(i_core_busy),
      .i_backend_read_data(i_backend_read_data),
      .i_host_write_data(i_host_write_data),
      .i_data_sel_backend(i_data_sel_backend),
      .i_backend_data_drive_en(i_backend_data_drive_en),
      .i_host_data_drive_en(i_host_data_drive_en),
      .o_host_write_strobe_n(o_host_write_strobe_n),
      .o_host_write_n(o_host_write_n),
      .o_legacy_high_irq_n(o_legacy_high_irq_n),
      .o_legacy_message_irq_n(o_legacy_message_irq_n),
      .o_legacy_terminal_active_n(o_legacy_terminal_active_n),
      .o_legacy_rom_enable_n(o_legacy_rom_enable_n),
      .o_legacy_data_input(o_legacy_data_input),
      .o_legacy_data_drive_en(o_legacy_data_drive_en)
   );

   ptr_step_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ctrl_mon_en_r && i_msg_captured && !extra_r |=>
      ptr_r == $past(ptr_r) + lchm_pkg::DESC_STRIDE &&
      o_desc_wr.addr == $past(ptr_r)) // RULE_01
      else $error("pointer did not step by eight");
   blk_irq_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      blk_evt |=> int_stat_r[lchm_pkg::IRQ_BLK] && extra_r &&
      ptr_r != init_ptr_r) // RULE_02
      else $error("block count interrupt missing");
   extra_seq_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ctrl_mon_en_r && i_msg_captured && extra_r |=>
      o_desc_wr.addr == iaw_r + lchm_pkg::DESC_STRIDE) // RULE_03
      else $error("extra message not sequential");
   ptr_reload_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      ctrl_mon_en_r && i_msg_captured && extra_r |=>
      ptr_r == $past(init_ptr_r) && !extra_r) // RULE_04
      else $error("pointer not reloaded after extra");
   iaw_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      blk_evt |=> iaw_r == $past(ptr_r)) // RULE_05
      else $error("interrupt address word wrong");
   health_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_health_evt.mem_fail |=> health_r[lchm_pkg::HB_MEM]) // RULE_06
      else $error("memory fail bit not set");
   loop_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_health_evt.loop_fail |=> health_r[lchm_pkg::HB_LOOP]) // RULE_07
      else $error("loopback fail bit not set");
   parity_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $rose(tapar_err) |=> health_r[lchm_pkg::HB_TAPAR] &&
      o_terminal_addr_error) // RULE_08
      else $error("parity bit not set");
   txa_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_health_evt.tx_timeout_a |=> health_r[lchm_pkg::HB_TXA]) // RULE_09
      else $error("channel a timeout bit not set");
   txb_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      i_health_evt.tx_timeout_b |=> health_r[lchm_pkg::HB_TXB]) // RULE_10
      else $error("channel b timeout bit not set");
   hw_quiet_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      !wr_health |=> health_r[lchm_pkg::HB_SELFTEST] ==
      $past(health_r[lchm_pkg::HB_SELFTEST]) &&
      health_r[lchm_pkg::UDB_W-1:0] ==
      $past(health_r[lchm_pkg::UDB_W-1:0])) // RULE_11
      else $error("hardware changed host-only bits");
   host_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      wr_health && wr_strb_r[1:0] == 2'b11 && !health_evt_any |=>
      health_r == $past(wr_data_r[15:0])) // RULE_12
      else $error("host write to health word lost");
   buf_zero_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_s_axi_rvalid && $past(i_s_axi_araddr == lchm_pkg::ADDR_CTRL &&
      i_s_axi_arvalid && o_s_axi_arready) |->
      o_s_axi_rdata[lchm_pkg::CTRL_BUF_MODE] == 1'b0) // RULE_14
      else $error("buffer mode bit read nonzero");
endmodule // lchm_top

// ---- lchm_pkg.sv ----
// shared constants and types of the legacy compatibility health monitor
package lchm_pkg;
   localparam int AXI_AW = 8;
   localparam int DW = 16;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INIT_PTR = 8'h04;
   localparam logic [7:0] ADDR_BLK_CNT = 8'h08;
   localparam logic [7:0] ADDR_MON_PTR = 8'h0c;
   localparam logic [7:0] ADDR_IAW = 8'h10;
   localparam logic [7:0] ADDR_INT_STAT = 8'h20;
   localparam logic [7:0] ADDR_INT_MASK = 8'h24;
   // health word index; byte address is four times it
   localparam logic [5:0] HEALTH_IDX = 6'h06;
   localparam logic [7:0] ADDR_HEALTH = {HEALTH_IDX, 2'b00};
   // health word fields
   localparam int HB_MEM = 15;
   localparam int HB_LOOP = 14;
   localparam int HB_TAPAR = 13;
   localparam int HB_SELFTEST = 12;
   localparam int HB_TXA = 11;
   localparam int HB_TXB = 10;
   localparam int UDB_W = 10;
   // control fields
   localparam int CTRL_MON_EN = 0;
   localparam int CTRL_BUF_MODE = 6;
   // interrupt status fields
   localparam int IRQ_W = 2;
   localparam int IRQ_BLK = 0;
   localparam int IRQ_HEALTH = 1;
   // reset values and steps
   localparam logic [15:0] INIT_PTR_RST = 16'h0000;
   localparam logic [15:0] BLK_CNT_RST = 16'h0004;
   localparam logic [15:0] DESC_STRIDE = 16'h0008;
   localparam logic [15:0] ONE16 = 16'h0001;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic mem_fail;
      logic loop_fail;
      logic tx_timeout_a;
      logic tx_timeout_b;
   } lchm_health_evt_t;

   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } lchm_desc_wr_t;
endpackage

// ---- lchm_legacy_wrap.sv ----
// legacy pinout mapping onto the core host and status signals
`timescale 1ns/1ps
module lchm_legacy_wrap (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_legacy_chip_select_n,
   input wire logic i_legacy_read_write_n,
   input wire logic i_high_prio_irq_out,
   input wire logic i_message_irq_out,
   input wire logic i_core_busy,
   input wire logic [15:0] i_backend_read_data,
   input wire logic [15:0] i_host_write_data,
   input wire logic i_data_sel_backend,
   input wire logic i_backend_data_drive_en,
   input wire logic i_host_data_drive_en,
   output logic o_host_write_strobe_n,
   output logic o_host_write_n,
   output logic o_legacy_high_irq_n,
   output logic o_legacy_message_irq_n,
   output logic o_legacy_terminal_active_n,
   output logic o_legacy_rom_enable_n,
   output logic [15:0] o_legacy_data_input,
   output logic o_legacy_data_drive_en
);
   logic cs_s1_r, cs_s2_r, rw_s1_r, rw_s2_r;
   logic wr_n;

   // pin synchronisers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         rw_s1_r <= 1'b1;
         rw_s2_r <= 1'b1;
      end else begin
         cs_s1_r <= i_legacy_chip_select_n;
         cs_s2_r <= cs_s1_r;
         rw_s1_r <= i_legacy_read_write_n;
         rw_s2_r <= rw_s1_r;
      end
   end

   assign wr_n = !(!cs_s2_r && !rw_s2_r); // RULE_16

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_host_write_strobe_n <= 1'b1;
         o_host_write_n <= 1'b1;
         o_legacy_high_irq_n <= 1'b1;
         o_legacy_message_irq_n <= 1'b1;
         o_legacy_terminal_active_n <= 1'b1;
         o_legacy_rom_enable_n <= 1'b1;
         o_legacy_data_input <= 16'h0000;
         o_legacy_data_drive_en <= 1'b0;
      end else begin
         o_host_write_strobe_n <= wr_n; // RULE_16
         o_host_write_n <= wr_n;
         o_legacy_high_irq_n <= !i_high_prio_irq_out; // RULE_18
         o_legacy_message_irq_n <= !i_message_irq_out; // RULE_18
         o_legacy_terminal_active_n <= !i_core_busy; // RULE_19
         o_legacy_rom_enable_n <= 1'b1; // RULE_19
         o_legacy_data_input <= i_data_sel_backend ? i_backend_read_data
                                                   : i_host_write_data; // RULE_17
         o_legacy_data_drive_en <= i_backend_data_drive_en
                                   | i_host_data_drive_en;
      end
   end

   strobe_map_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $past(!cs_s2_r && !rw_s2_r) == !o_host_write_strobe_n) // RULE_16
      else $error("write strobe not cs and rw low");
   data_mux_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      $past(i_data_sel_backend) |->
      o_legacy_data_input == $past(i_backend_read_data)) // RULE_17
      else $error("data input not from backend");
   irq_invert_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_legacy_message_irq_n == !$past(i_message_irq_out) &&
      o_legacy_high_irq_n == !$past(i_high_prio_irq_out)) // RULE_18
      else $error("legacy irq not inverted");
   rom_busy_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
      o_legacy_rom_enable_n &&
      o_legacy_terminal_active_n == !$past(i_core_busy)) // RULE_19
      else $error("rom enable or terminal active wrong");
endmodule // lchm_legacy_wrap

// ---- lchm_backend_model.sv ----
// backend memory model feeding the legacy data mux
`timescale 1ns/1ps
module lchm_backend_model #(
   parameter logic [15:0] MEM_WORD = 16'hc35a
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_rd_en,
   output logic [15:0] o_rdata,
   output logic o_drive_en
);
   // released bus walks a ring pattern, never the last value
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 16'h0001;
         o_drive_en <= 1'b0;
      end else begin
         o_rdata <= i_rd_en ? MEM_WORD : {o_rdata[14:0], ~o_rdata[15]};
         o_drive_en <= i_rd_en;
      end
   end
endmodule // lchm_backend_model

// ---- lchm_top_test.sv ----
// self-checking bench for the health monitor block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
$display("[ERR] %s exp %h got %h", nm, e, g); end end
module lchm_top_test;
   localparam logic [9:0] VER = 10'h1c3; // arbitrary value
   logic i_clk, i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
   logic i_s_axi_arvalid, i_s_axi_rready, i_msg_captured, i_core_busy, rd_en;
   logic i_terminal_addr_parity_in, i_legacy_chip_select_n, o_irq;
   logic i_legacy_read_write_n, i_data_sel_backend, i_host_data_drive_en;
   logic i_backend_data_drive_en, o_s_axi_awready, o_s_axi_wready;
   logic o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid, o_host_write_n;
   logic o_terminal_addr_error, o_host_write_strobe_n, o_legacy_high_irq_n;
   logic o_legacy_message_irq_n, o_legacy_terminal_active_n;
   logic o_legacy_rom_enable_n, o_legacy_data_drive_en;
   logic [7:0] i_s_axi_awaddr, i_s_axi_araddr;
   logic [31:0] i_s_axi_wdata, o_s_axi_rdata, rdat;
   logic [1:0] o_s_axi_bresp, o_s_axi_rresp, resp;
   logic [4:0] i_terminal_address_in;
   logic [15:0] i_backend_read_data, i_host_write_data, o_legacy_data_input;
   lchm_pkg::lchm_health_evt_t i_health_evt;
   lchm_pkg::lchm_desc_wr_t o_desc_wr;
   int n_fail = 0;
   int num_checks = 0;
   lchm_top #(.VERSION(VER)) dut (.i_clk, .i_resetn, .i_s_axi_awaddr,
      .i_s_axi_awprot(3'h0), .i_s_axi_awvalid, .o_s_axi_awready,
      .i_s_axi_wdata, .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid, .o_s_axi_wready,
      .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr,
      .i_s_axi_arprot(3'h0), .i_s_axi_arvalid, .o_s_axi_arready,
      .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
      .i_msg_captured, .i_health_evt, .i_terminal_address_in,
      .i_terminal_addr_parity_in, .i_core_busy, .i_legacy_chip_select_n,
      .i_legacy_read_write_n, .i_backend_read_data, .i_host_write_data,
      .i_data_sel_backend, .i_backend_data_drive_en, .i_host_data_drive_en,
      .o_desc_wr, .o_terminal_addr_error, .o_irq, .o_host_write_strobe_n,
      .o_host_write_n, .o_legacy_high_irq_n, .o_legacy_message_irq_n,
      .o_legacy_terminal_active_n, .o_legacy_rom_enable_n,
      .o_legacy_data_input, .o_legacy_data_drive_en);
   lchm_backend_model bem (.i_clk, .i_resetn, .i_rd_en(rd_en),
      .o_rdata(i_backend_read_data), .o_drive_en(i_backend_data_drive_en));
   task automatic tick(input int k);
      repeat (k) @(posedge i_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      i_s_axi_awaddr <= a;
      i_s_axi_wdata <= {16'h0000, d};
      {i_s_axi_awvalid, i_s_axi_wvalid} <= 2'h3;
      do begin
         @(posedge i_clk);
         if (o_s_axi_awready) i_s_axi_awvalid <= 1'b0;
         if (o_s_axi_wready) i_s_axi_wvalid <= 1'b0;
      end while (o_s_axi_bvalid !== 1'b1);
      resp = o_s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      i_s_axi_araddr <= a;
      i_s_axi_arvalid <= 1'b1;
      do begin
         @(posedge i_clk);
         if (o_s_axi_arready) i_s_axi_arvalid <= 1'b0;
      end while (o_s_axi_rvalid !== 1'b1);
      rdat = o_s_axi_rdata;
      resp = o_s_axi_rresp;
   endtask
   task automatic t_regs;
      rd(8'h18);
      `CHK("health rst", {22'h0, VER}, rdat)
      rd(8'h3c);
      `CHK("unmapped", lchm_pkg::RESP_SLVERR, resp)
      wr(8'h3c, 16'h0000);
      `CHK("wr unmapped", lchm_pkg::RESP_SLVERR, resp)
      wr(8'h18, 16'hffff);
      `CHK("wr resp", lchm_pkg::RESP_OKAY, resp)
      rd(8'h18);
      `CHK("health set", 32'hffff, rdat)
   endtask
   task automatic t_events;
      logic [15:0] ev [4] = '{16'h8000, 16'h4000, 16'h0800, 16'h0400};
      wr(8'h24, 16'h0003);
      for (int i = 0; i < 4; i++) begin
         wr(8'h18, 16'h0000);
         i_health_evt <= 4'h8 >> i;
         tick(1);
         i_health_evt <= 4'h0;
         rd(8'h18);
         `CHK("health evt", {16'h0, ev[i]}, rdat)
      end
      `CHK("irq", 1'b1, o_irq)
      `CHK("high irq", 1'b0, o_legacy_high_irq_n)
      wr(8'h20, 16'h0002);
      tick(2);
      `CHK("irq clr", 1'b0, o_irq)
      wr(8'h18, 16'h0000);
      i_terminal_addr_parity_in <= 1'b0;
      tick(5);
      `CHK("par err", 1'b1, o_terminal_addr_error)
      i_terminal_addr_parity_in <= 1'b1;
      rd(8'h18);
      `CHK("par flag", 32'h2000, rdat)
   endtask
   task automatic t_monitor;
      logic [15:0] e;
      e = 16'h1ff8;
      wr(8'h04, 16'h2000);
      wr(8'h08, 16'h0004);
      wr(8'h00, 16'h0041);
      rd(8'h00);
      `CHK("buf mode", 32'h1, rdat)
      for (int k = 0; k < 7; k++) begin
         e = (k == 5) ? 16'h2000 : e + 16'h0008;
         i_msg_captured <= 1'b1;
         tick(1);
         i_msg_captured <= 1'b0;
         tick(1);
         `CHK("desc", {1'b1, e}, o_desc_wr)
         if (k == 3) begin
            rd(8'h10);
            `CHK("iaw", 32'h2018, rdat)
            `CHK("msg irq", 1'b0, o_legacy_message_irq_n)
         end
      end
   endtask
   task automatic t_legacy;
      for (int i = 0; i < 4; i++) begin
         {i_legacy_chip_select_n, i_legacy_read_write_n} <= i[1:0];
         tick(4);
         `CHK("strobe", i != 0, o_host_write_strobe_n)
         `CHK("wr line", i != 0, o_host_write_n)
      end
      {i_core_busy, i_data_sel_backend, rd_en} <= 3'h7;
      tick(3);
      `CHK("term act", 1'b0, o_legacy_terminal_active_n)
      `CHK("rom en", 1'b1, o_legacy_rom_enable_n)
      `CHK("data be", 16'hc35a, o_legacy_data_input)
      `CHK("data en", 1'b1, o_legacy_data_drive_en)
      {i_data_sel_backend, rd_en} <= 2'h0;
      tick(3);
      `CHK("data host", 16'h9e17, o_legacy_data_input)
      `CHK("data off", 1'b0, o_legacy_data_drive_en)
   endtask
   task automatic stop_test;
      if (n_fail == 0 && num_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   initial begin
      {i_resetn, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid} = '0;
      {i_msg_captured, i_core_busy} = '0;
      {i_s_axi_bready, i_s_axi_rready} = 2'h3;
      {i_data_sel_backend, i_host_data_drive_en, rd_en} = '0;
      {i_legacy_chip_select_n, i_legacy_read_write_n} = 2'h3;
      {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
      {i_terminal_address_in, i_terminal_addr_parity_in} = 6'h01;
      i_health_evt = 4'h0;
      i_host_write_data = 16'h9e17;
      repeat (20) @(posedge i_clk);
      i_resetn <= 1'b1;
      tick(1);
      t_regs;
      t_events;
      t_monitor;
      t_legacy;
      stop_test;
   end
   initial begin
      #80000;
      n_fail++;
      stop_test;
   end
endmodule // lchm_top_test
